// ===== verilog/oemc_pkg.sv
// package: command codes, field positions, encodings and reset values
package oemc_pkg;
  localparam logic [7:0] CMD_OUTPUT_CTRL = 8'h01;
  localparam logic [7:0] CMD_SOURCE_CFG = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  // output control byte fields
  localparam int EN_HI = 7;
  localparam int EN_LO = 6;
  localparam int MRG_HI = 5;
  localparam int MRG_LO = 4;
  localparam int AOF_HI = 3;
  localparam int AOF_LO = 2;
  localparam logic [1:0] EN_IMM_OFF = 2'h0;
  localparam logic [1:0] EN_SOFT_OFF = 2'h1;
  localparam logic [1:0] EN_ON = 2'h2;
  localparam logic [1:0] MRG_NOM = 2'h0;
  localparam logic [1:0] MRG_LOW = 2'h1;
  localparam logic [1:0] MRG_HIGH = 2'h2;
  localparam logic [1:0] AOF_IGNORE = 2'h1;
  localparam logic [1:0] AOF_ACT = 2'h2;
  // source configuration bits
  localparam int CFG_PWRUP = 4;
  localparam int CFG_USE_BUS = 3;
  localparam int CFG_USE_PIN = 2;
  localparam int CFG_POL = 1;
  localparam int CFG_IMM = 0;
  // reset values: output off immediately, nominal, act on faults
  localparam logic [7:0] OUTPUT_CTRL_RST = 8'h08;
  localparam logic [7:0] SOURCE_CFG_RST = 8'h1E;
  // output states
  typedef enum logic [1:0] {OEMC_OFF, OEMC_RUN, OEMC_SOFT_STOP} oemc_state_t;
endpackage

// ===== verilog/oemc_field_hold.sv
// two-bit field holder that keeps the last described encoding
module oemc_field_hold #(
  parameter logic [1:0] RST_VAL = 2'h0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [1:0] value,
  output logic [1:0] field
);
  // code 11 is reserved for every field; it is dropped so state never moves on it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      field <= RST_VAL;
    end else if (load && value != 2'h3) begin
      field <= value;
    end
  end
endmodule

// ===== verilog/oemc_onoff_arbiter.sv
// start-condition combiner for pin, bus and power-up sources
module oemc_onoff_arbiter (
  input wire logic [7:0] cfg,
  input wire logic [1:0] en_field,
  input wire logic pin_level,
  output logic run_req,
  output logic pin_off
);
  logic pin_active;
  logic bus_on;
  // polarity: 0 active low, 1 active high
  assign pin_active = cfg[oemc_pkg::CFG_POL] ? pin_level : !pin_level;
  assign bus_on = (en_field == oemc_pkg::EN_ON);
  // all enabled conditions must hold; bit 4 clear means always on
  always_comb begin
    if (!cfg[oemc_pkg::CFG_PWRUP]) begin
      run_req = 1'b1;
    end else begin
      run_req = (!cfg[oemc_pkg::CFG_USE_BUS] || bus_on)
        && (!cfg[oemc_pkg::CFG_USE_PIN] || pin_active);
    end
  end
  // the pin is the cause of turn-off only when it is in use and withdrawn
  assign pin_off = cfg[oemc_pkg::CFG_PWRUP] && cfg[oemc_pkg::CFG_USE_PIN] && !pin_active;
endmodule

// ===== verilog/oemc_top.sv
// output enable and margin control core with byte command port
module oemc_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmd_write,
  input wire logic cmd_read,
  input wire logic cmd_send,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  output logic [7:0] cmd_rdata,
  output logic cmd_ack,
  output logic cmd_nak,
  input wire logic enable_pin,
  input wire logic ov_warn_in,
  input wire logic uv_warn_in,
  input wire logic ov_fault_in,
  input wire logic uv_fault_in,
  input wire logic stop_done,
  output logic output_run,
  output logic soft_stop,
  output logic hard_stop,
  output logic [1:0] margin_sel,
  output logic ov_warn_act,
  output logic uv_warn_act,
  output logic ov_fault_act,
  output logic uv_fault_act,
  output logic clear_faults
);
  logic [1:0] en_field;
  logic [1:0] mrg_field;
  logic [1:0] aof_field;
  logic [7:0] cfg_reg;
  logic wr_ctrl;
  logic run_req;
  logic pin_off;
  logic imm_off;
  logic margined;
  logic faults_on;
  oemc_pkg::oemc_state_t state_reg;
  oemc_pkg::oemc_state_t state_next;

  assign wr_ctrl = cmd_write && cmd_code == oemc_pkg::CMD_OUTPUT_CTRL;

  // each field of the output control byte held separately, reserved codes dropped
  oemc_field_hold #(.RST_VAL(oemc_pkg::OUTPUT_CTRL_RST[oemc_pkg::EN_HI:oemc_pkg::EN_LO]))
    u_en (.sys_clk(sys_clk), .sys_rst(sys_rst), .load(wr_ctrl),
    .value(cmd_wdata[oemc_pkg::EN_HI:oemc_pkg::EN_LO]), .field(en_field));
  oemc_field_hold #(.RST_VAL(oemc_pkg::OUTPUT_CTRL_RST[oemc_pkg::MRG_HI:oemc_pkg::MRG_LO]))
    u_mrg (.sys_clk(sys_clk), .sys_rst(sys_rst), .load(wr_ctrl),
    .value(cmd_wdata[oemc_pkg::MRG_HI:oemc_pkg::MRG_LO]), .field(mrg_field));
  oemc_field_hold #(.RST_VAL(oemc_pkg::OUTPUT_CTRL_RST[oemc_pkg::AOF_HI:oemc_pkg::AOF_LO]))
  // fault code 00 is undescribed as well, so it is dropped here besides 11
    u_aof (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .load(wr_ctrl && cmd_wdata[oemc_pkg::AOF_HI:oemc_pkg::AOF_LO] != 2'h0),
    .value(cmd_wdata[oemc_pkg::AOF_HI:oemc_pkg::AOF_LO]), .field(aof_field));

  // configuration byte; bits 7:5 are not defined and read as zero
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_reg <= oemc_pkg::SOURCE_CFG_RST;
    end else if (cmd_write && cmd_code == oemc_pkg::CMD_SOURCE_CFG) begin
      cfg_reg <= {3'h0, cmd_wdata[4:0]};
    end
  end

  oemc_onoff_arbiter u_arb (
    .cfg(cfg_reg),
    .en_field(en_field),
    .pin_level(enable_pin),
    .run_req(run_req),
    .pin_off(pin_off)
  );

  // how the stop goes: pin turn-off follows config bit 0, otherwise the enable field when bus control is enabled, else sequenced
  always_comb begin
    if (pin_off) begin
      imm_off = cfg_reg[oemc_pkg::CFG_IMM];
    end else if (cfg_reg[oemc_pkg::CFG_PWRUP] && cfg_reg[oemc_pkg::CFG_USE_BUS]) begin
      imm_off = (en_field == oemc_pkg::EN_IMM_OFF);
    end else begin
      imm_off = 1'b0;
    end
  end

  // output state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      oemc_pkg::OEMC_OFF: begin
        if (run_req) begin
          state_next = oemc_pkg::OEMC_RUN;
        end
      end
      oemc_pkg::OEMC_RUN: begin
        if (!run_req) begin
          state_next = imm_off ? oemc_pkg::OEMC_OFF : oemc_pkg::OEMC_SOFT_STOP;
        end
      end
      oemc_pkg::OEMC_SOFT_STOP: begin
        // a sequenced stop can be cut short by an immediate request
        if (imm_off || stop_done) begin
          state_next = oemc_pkg::OEMC_OFF;
        end
      end
      default: begin
        state_next = oemc_pkg::OEMC_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= oemc_pkg::OEMC_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // registered output controls
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      output_run <= 1'b0;
      soft_stop <= 1'b0;
      hard_stop <= 1'b1;
      margin_sel <= oemc_pkg::MRG_NOM;
    end else begin
      output_run <= (state_next == oemc_pkg::OEMC_RUN);
      soft_stop <= (state_next == oemc_pkg::OEMC_SOFT_STOP);
      hard_stop <= (state_next == oemc_pkg::OEMC_OFF);
      margin_sel <= mrg_field;
    end
  end

  // fault gating while margined
  assign margined = (mrg_field != oemc_pkg::MRG_NOM);
  assign faults_on = !margined || (aof_field == oemc_pkg::AOF_ACT);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ov_warn_act <= 1'b0;
      uv_warn_act <= 1'b0;
      ov_fault_act <= 1'b0;
      uv_fault_act <= 1'b0;
    end else begin
      ov_warn_act <= ov_warn_in && faults_on;
      uv_warn_act <= uv_warn_in && faults_on;
      ov_fault_act <= ov_fault_in && faults_on;
      uv_fault_act <= uv_fault_in && faults_on;
    end
  end

  // clear pulse to the fault status store, one cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clear_faults <= 1'b0;
    end else begin
      clear_faults <= cmd_send && cmd_code == oemc_pkg::CMD_CLEAR_FAULTS;
    end
  end

  // command answer one cycle after the request; unknown codes are refused
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_rdata <= 8'h00;
      cmd_ack <= 1'b0;
      cmd_nak <= 1'b0;
    end else begin
      cmd_ack <= 1'b0;
      cmd_nak <= 1'b0;
      if (cmd_read) begin
        if (cmd_code == oemc_pkg::CMD_OUTPUT_CTRL) begin
          cmd_rdata <= {en_field, mrg_field, aof_field, 2'h0};
          cmd_ack <= 1'b1;
        end else if (cmd_code == oemc_pkg::CMD_SOURCE_CFG) begin
          cmd_rdata <= cfg_reg;
          cmd_ack <= 1'b1;
        end else begin
          cmd_rdata <= 8'h00;
          cmd_nak <= 1'b1;
        end
      end else if (cmd_write) begin
        cmd_ack <= cmd_code == oemc_pkg::CMD_OUTPUT_CTRL || cmd_code == oemc_pkg::CMD_SOURCE_CFG;
        cmd_nak <= !(cmd_code == oemc_pkg::CMD_OUTPUT_CTRL
          || cmd_code == oemc_pkg::CMD_SOURCE_CFG);
      end else if (cmd_send) begin
        cmd_ack <= cmd_code == oemc_pkg::CMD_CLEAR_FAULTS;
        cmd_nak <= cmd_code != oemc_pkg::CMD_CLEAR_FAULTS;
      end
    end
  end

  // checks
  chk_run_follows_req: assert property (@(posedge sys_clk) disable iff (sys_rst)
    output_run |-> $past(run_req))
    else $error("output ran without all start conditions");
  chk_always_on: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !cfg_reg[oemc_pkg::CFG_PWRUP] && state_reg == oemc_pkg::OEMC_OFF |=> output_run)
    else $error("output not started with power-up always on");
  chk_pin_imm_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state_reg == oemc_pkg::OEMC_RUN && !run_req && pin_off && cfg_reg[oemc_pkg::CFG_IMM]
    |=> hard_stop && !soft_stop)
    else $error("pin immediate off not immediate");
  chk_pin_soft_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state_reg == oemc_pkg::OEMC_RUN && !run_req && pin_off && !cfg_reg[oemc_pkg::CFG_IMM]
    |=> soft_stop)
    else $error("pin soft off skipped sequencing");
  chk_fault_mask: assert property (@(posedge sys_clk) disable iff (sys_rst)
    margined && aof_field == oemc_pkg::AOF_IGNORE && $stable(mrg_field)
    |=> !ov_fault_act && !uv_fault_act && !ov_warn_act && !uv_warn_act)
    else $error("fault passed while ignored in margin");
  chk_fault_pass: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ov_fault_in && faults_on |=> ov_fault_act)
    else $error("fault dropped while acting on faults");
  chk_clear_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cmd_send && cmd_code == oemc_pkg::CMD_CLEAR_FAULTS |=> clear_faults ##1 !clear_faults
    or cmd_send && cmd_code == oemc_pkg::CMD_CLEAR_FAULTS)
    else $error("clear faults pulse missing");
  chk_reserved_keep: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_ctrl && cmd_wdata[oemc_pkg::EN_HI:oemc_pkg::EN_LO] == 2'h3 |=> $stable(en_field))
    else $error("reserved enable code changed state");
  chk_ctrl_readback: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_ctrl && cmd_wdata[7:6] != 2'h3 && cmd_wdata[5:4] != 2'h3 && cmd_wdata[3:2] != 2'h3
    && cmd_wdata[3:2] != 2'h0
    ##1 cmd_read && cmd_code == oemc_pkg::CMD_OUTPUT_CTRL && !wr_ctrl
    |=> cmd_rdata == {$past(cmd_wdata, 2) & 8'hFC})
    else $error("output control byte readback mismatch");
endmodule

// ===== verification/oemc_stage_model.sv
// power stage model: answers a sequenced turn-off with stop_done after a lag
module oemc_stage_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic soft_stop,
  input wire logic [7:0] lag,
  output logic stop_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_reg;
  // fall time count restarts on every new turn-off, so a short lag is prompt
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 8'h00;
    end else if (!soft_stop) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg != lag) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  // level drops as soon as the turn-off request goes away
  assign stop_done = soft_stop && (cnt_reg == lag);
endmodule

// ===== verification/oemc_bench.sv
// bench: command port, on/off sources, margin levels and fault gating
module oemc_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [2:0] RD = 3'h4;
  localparam logic [2:0] WR = 3'h2;
  localparam logic [2:0] SN = 3'h1;
  logic sys_clk, sys_rst, cmd_write, cmd_read, cmd_send, enable_pin, stop_done;
  logic [7:0] cmd_code, cmd_wdata, cmd_rdata, lag;
  logic cmd_ack, cmd_nak, output_run, soft_stop, hard_stop, clear_faults;
  logic [1:0] margin_sel;
  logic [3:0] mon, act;
  logic [17:0] r;
  int err_total = 0;
  int n_checks = 0;
  // rows: config byte, control byte, pin level, expected run
  logic [17:0] rows [10] = '{
    {8'h1E, 8'h88, 1'h1, 1'h1}, {8'h1E, 8'h98, 1'h1, 1'h1},
    {8'h1E, 8'hA8, 1'h1, 1'h1}, {8'h1E, 8'hA8, 1'h0, 1'h0},
    {8'h1C, 8'h88, 1'h0, 1'h1}, {8'h1A, 8'h88, 1'h0, 1'h1},
    {8'h16, 8'h48, 1'h1, 1'h1}, {8'h1E, 8'h48, 1'h1, 1'h0},
    {8'h0E, 8'h08, 1'h0, 1'h1}, {8'h1E, 8'h08, 1'h1, 1'h0}};

  oemc_top u_oemc_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_write(cmd_write),
    .cmd_read(cmd_read), .cmd_send(cmd_send), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_nak(cmd_nak), .enable_pin(enable_pin),
    .ov_warn_in(mon[3]), .uv_warn_in(mon[2]), .ov_fault_in(mon[1]), .uv_fault_in(mon[0]),
    .stop_done(stop_done), .output_run(output_run), .soft_stop(soft_stop),
    .hard_stop(hard_stop), .margin_sel(margin_sel), .ov_warn_act(act[3]),
    .uv_warn_act(act[2]), .ov_fault_act(act[1]), .uv_fault_act(act[0]),
    .clear_faults(clear_faults));
  oemc_stage_model u_oemc_stage_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .soft_stop(soft_stop), .lag(lag), .stop_done(stop_done));

  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one request strobe, answer looked at in the single cycle it stands
  task automatic cmd(input logic [2:0] k, input logic [7:0] c, input logic [7:0] d,
    input logic nk);
    @(posedge sys_clk);
    #10;
    {cmd_read, cmd_write, cmd_send} = k;
    cmd_code = c;
    cmd_wdata = d;
    @(posedge sys_clk);
    #10;
    {cmd_read, cmd_write, cmd_send} = 3'h0;
    chk({cmd_ack, cmd_nak}, {!nk, nk});
  endtask

  task automatic settle();
    repeat (4) @(posedge sys_clk);
    #10;
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // a hang must not outlast about 5000 cycles
  initial begin
    #(100 * 5000);
    err_total++;
    report_and_stop();
  end

  initial begin
    sys_clk = 1'h0;
    sys_rst = 1'h1;
    {cmd_write, cmd_read, cmd_send} = 3'h0;
    cmd_code = 8'h00;
    cmd_wdata = 8'h00;
    enable_pin = 1'h0;
    mon = 4'h0;
    lag = 8'h01;
    repeat (3) @(posedge sys_clk);
    #10;
    sys_rst = 1'h0;
    for (int i = 0; i < 10; i++) begin
      r = rows[i];
      cmd(WR, 8'h02, r[17:10], 1'h0);
      cmd(WR, 8'h01, r[9:2], 1'h0);
      enable_pin = r[1];
      settle();
      chk(output_run, r[0]);
      chk(margin_sel, r[7:6]);
      cmd(RD, 8'h01, 8'h00, 1'h0);
      chk(cmd_rdata, r[9:2]);
    end
    // reset in mid-run, then the awkward cases from reset state
    sys_rst = 1'h1;
    lag = 8'h14;
    repeat (3) @(posedge sys_clk);
    #10;
    sys_rst = 1'h0;
    chk({output_run, hard_stop}, 8'h01);
    cmd(RD, 8'h01, 8'h00, 1'h0);
    chk(cmd_rdata, 8'h08);
    cmd(RD, 8'h02, 8'h00, 1'h0);
    chk(cmd_rdata, 8'h1E);
    cmd(RD, 8'h7F, 8'h00, 1'h1);
    cmd(SN, 8'h01, 8'h00, 1'h1);
    cmd(WR, 8'h02, 8'hFF, 1'h0);
    cmd(RD, 8'h02, 8'h00, 1'h0);
    chk(cmd_rdata, 8'h1F);
    enable_pin = 1'h1;
    mon = 4'hF;
    cmd(WR, 8'h01, 8'h98, 1'h0);
    settle();
    chk(act, 8'h0F);
    cmd(WR, 8'h01, 8'h94, 1'h0);
    settle();
    chk(act, 8'h00);
    cmd(WR, 8'h01, 8'h84, 1'h0);
    settle();
    chk(act, 8'h0F);
    mon = 4'h0;
    cmd(WR, 8'h01, 8'hFC, 1'h0);
    settle();
    chk(output_run, 8'h01);
    cmd(RD, 8'h01, 8'h00, 1'h0);
    chk(cmd_rdata, 8'h84);
    // pin turn-off: immediate with bit 0 set, sequenced with it clear
    enable_pin = 1'h0;
    settle();
    chk({output_run, soft_stop, hard_stop}, 8'h01);
    cmd(WR, 8'h02, 8'h1E, 1'h0);
    enable_pin = 1'h1;
    settle();
    enable_pin = 1'h0;
    settle();
    chk({output_run, soft_stop, hard_stop}, 8'h02);
    repeat (25) @(posedge sys_clk);
    #10;
    chk({output_run, soft_stop, hard_stop}, 8'h01);
    enable_pin = 1'h1;
    settle();
    // bus turn-off: soft code waits for the stage, immediate code does not
    cmd(WR, 8'h01, 8'h44, 1'h0);
    settle();
    chk({output_run, soft_stop, hard_stop}, 8'h02);
    repeat (25) @(posedge sys_clk);
    #10;
    chk({output_run, soft_stop, hard_stop}, 8'h01);
    cmd(WR, 8'h01, 8'h84, 1'h0);
    settle();
    chk(output_run, 8'h01);
    cmd(WR, 8'h01, 8'h04, 1'h0);
    settle();
    chk({output_run, soft_stop, hard_stop}, 8'h01);
    cmd(SN, 8'h03, 8'h00, 1'h0);
    chk(clear_faults, 8'h01);
    settle();
    chk(clear_faults, 8'h00);
    // write then read on the very next edge, with an undescribed fault code
    cmd_write = 1'h1;
    cmd_code = 8'h01;
    cmd_wdata = 8'h80;
    @(posedge sys_clk);
    #10;
    chk(cmd_ack, 8'h01);
    {cmd_read, cmd_write} = 2'h2;
    @(posedge sys_clk);
    #10;
    cmd_read = 1'h0;
    chk(cmd_ack, 8'h01);
    chk(cmd_rdata, 8'h84);
    report_and_stop();
  end
endmodule
